// File: src/rsc_pkg.sv
// Package for the receive sync and correlator configuration block
package rsc_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_SOF_HIGH  = 8'h5A;
   localparam logic [7:0] IDX_SOF_LOW   = 8'h5B;
   localparam logic [7:0] IDX_SYNC_MODE = 8'h5C;
   localparam logic [7:0] IDX_DEMOD     = 8'h5D;
   localparam logic [7:0] IDX_CORR      = 8'h5E;
   localparam logic [7:0] IDX_TRIM      = 8'h5F;
   localparam logic [7:0] IDX_STATUS    = 8'h60;
   localparam int ADDR_W = 10;
   // Reset values
   localparam logic [7:0] RST_SOF_HIGH  = 8'h00;
   localparam logic [7:0] RST_SOF_LOW   = 8'h00;
   localparam logic [7:0] RST_SYNC_MODE = 8'h00;
   localparam logic [7:0] RST_DEMOD     = 8'h00;
   localparam logic [7:0] RST_CORR      = 8'h00;
   localparam logic [7:0] RST_TRIM      = 8'h80;
   // Field positions
   localparam int SM_LEN_LSB  = 4;
   localparam int SM_NEG_EDGE = 3;
   localparam int SM_HALF     = 2;
   localparam int SM_KIND_LSB = 0;
   localparam int DM_AVG      = 5;
   localparam int DM_SQUARE   = 4;
   localparam int DM_PEAK     = 3;
   localparam int DM_POL      = 2;
   localparam int DM_FSK      = 1;
   localparam int DM_BPSK     = 0;
   localparam int CR_FREQ_LSB = 6;
   localparam int CR_RATE_LSB = 4;
   localparam int CR_WIN      = 3;
   localparam logic [7:0] DEMOD_MASK = 8'h3F;
   localparam logic [7:0] CORR_MASK  = 8'hF8;
   // Correlation window sizes
   localparam logic [6:0] WIN_LONG  = 7'h40;
   localparam logic [6:0] WIN_SHORT = 7'h20;
   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {RSC_KIND_BURST, RSC_KIND_NIBBLE, RSC_KIND_BYTE,
                             RSC_KIND_RSVD} rsc_kind_t;
   typedef enum logic [1:0] {RSC_F212, RSC_F424, RSC_F848} rsc_freq_t;
endpackage : rsc_pkg

// File: src/rsc_four_sample_average.sv
// Sample pre-filter: optional square shaping and four-sample averaging
module rsc_four_sample_average
   import rsc_pkg::*;
#(
   parameter int SW = 8
) (
   input  wire logic          clk,
   input  wire logic          rst_b,
   input  wire logic          square_shaping,
   input  wire logic          four_sample_average,
   input  wire logic          smp_valid,
   input  wire logic [SW-1:0] smp_data,
   output      logic          out_valid,
   output      logic [SW-1:0] out_data
);
   if (SW < 2) begin : g_bad_sw
      $error("SW too small");
   end
   typedef struct packed {
      logic [SW+1:0] acc;
      logic [1:0]    cnt;
      logic          vld;
      logic [SW-1:0] dat;
   } rsc_pf_t;
   rsc_pf_t st_ff, nxt_st;
   logic [SW-1:0] shaped;
   always_comb begin
      if (square_shaping) begin
         shaped = smp_data[SW-1] ? {SW{1'b1}} : {SW{1'b0}};
      end else begin
         shaped = smp_data;
      end
   end
   always_comb begin
      nxt_st = st_ff;
      nxt_st.vld = 1'b0;
      if (smp_valid) begin
         if (four_sample_average) begin
            nxt_st.cnt = st_ff.cnt + 2'h1;
            if (st_ff.cnt == 2'h3) begin
               nxt_st.acc = '0;
               nxt_st.vld = 1'b1;
               nxt_st.dat = SW'((st_ff.acc + (SW+2)'(shaped)) >> 2);
            end else begin
               nxt_st.acc = st_ff.acc + (SW+2)'(shaped);
            end
         end else begin
            nxt_st.vld = 1'b1;
            nxt_st.dat = shaped;
            nxt_st.cnt = 2'h0;
            nxt_st.acc = '0;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
   assign out_valid = st_ff.vld;
   assign out_data  = st_ff.dat;
   // one output per four inputs when averaging
   AST_AVG_GROUP: assert property (@(posedge clk) disable iff (!rst_b)
      four_sample_average && smp_valid && st_ff.cnt != 2'h3 |=> !out_valid)
      else $error("average emitted early");
   AST_SQUARE: assert property (@(posedge clk) disable iff (!rst_b)
      square_shaping && !four_sample_average && smp_valid
      |=> out_data == {SW{1'b1}} || out_data == {SW{1'b0}})
      else $error("shaped sample not rectangular");
   COV_AVG: cover property (@(posedge clk) disable iff (!rst_b)
      four_sample_average && out_valid);
endmodule : rsc_four_sample_average

// File: src/rsc_sync_match.sv
// Start-of-frame matcher against the programmed pattern
module rsc_sync_match
   import rsc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic [15:0] sof_pattern_value,
   input  wire logic [3:0]  sync_valid_bit_count,
   input  wire logic [1:0]  sync_pattern_kind,
   input  wire logic        bit_valid,
   input  wire logic        bit_data,
   input  wire logic        bit_coll,
   input  wire logic        frame_start,
   output      logic        sof_found,
   output      logic        sof_error,
   output      logic [3:0]  bit_index
);
   function automatic logic nib_expect(input logic [15:0] v, input logic [3:0] i,
                                       output logic coll);
      logic [3:0] nb;
      nb   = v[{i[1:0], 2'b00} +: 4];
      coll = nb[0];
      return nb[1];
   endfunction : nib_expect
   typedef struct packed {
      logic [3:0] idx;
      logic       hunt;
      logic       found;
      logic       err;
   } rsc_sm_t;
   rsc_sm_t st_ff, nxt_st;
   logic exp_bit;
   logic exp_coll;
   logic hit;
   logic last;
   always_comb begin
      exp_coll = 1'b0;
      exp_bit  = 1'b0;
      hit      = 1'b0;
      last     = 1'b0;
      case (rsc_kind_t'(sync_pattern_kind))
         RSC_KIND_NIBBLE: begin
            exp_bit = nib_expect(sof_pattern_value, st_ff.idx, exp_coll);
            hit  = exp_coll ? bit_coll : (!bit_coll && bit_data == exp_bit);
            last = (st_ff.idx + 4'h1 >= sync_valid_bit_count) || st_ff.idx == 4'h3;
         end
         RSC_KIND_BURST: begin
            exp_bit = sof_pattern_value[4'hF - st_ff.idx];
            hit  = !bit_coll && bit_data == exp_bit;
            last = st_ff.idx + 4'h1 >= sync_valid_bit_count;
         end
         RSC_KIND_BYTE: begin
            hit  = !bit_coll && !bit_data;
            last = 1'b1;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end
   always_comb begin
      nxt_st = st_ff;
      nxt_st.found = 1'b0;
      nxt_st.err   = 1'b0;
      if (frame_start) begin
         nxt_st.idx  = 4'h0;
         nxt_st.hunt = 1'b1;
      end else if (st_ff.hunt && bit_valid) begin
         if (sync_valid_bit_count == 4'h0 && sync_pattern_kind < 2'h2) begin
            nxt_st.found = 1'b1;
            nxt_st.hunt  = 1'b0;
         end else if (!hit) begin
            nxt_st.err  = 1'b1;
            nxt_st.hunt = 1'b0;
         end else if (last) begin
            nxt_st.found = 1'b1;
            nxt_st.hunt  = 1'b0;
         end else begin
            nxt_st.idx = st_ff.idx + 4'h1;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
   assign sof_found = st_ff.found;
   assign sof_error = st_ff.err;
   assign bit_index = st_ff.idx;
   AST_COLL_OK: assert property (@(posedge clk) disable iff (!rst_b)
      st_ff.hunt && bit_valid && !frame_start && sync_pattern_kind == 2'h1
      && exp_coll && bit_coll |=> !sof_error)
      else $error("expected collision rejected");
   AST_RSVD: assert property (@(posedge clk) disable iff (!rst_b)
      sync_pattern_kind == 2'h3 && sync_valid_bit_count != 4'h0 |=> !sof_found)
      else $error("reserved kind matched");
   COV_NIB: cover property (@(posedge clk) disable iff (!rst_b)
      sof_found && sync_pattern_kind == 2'h1);
endmodule : rsc_sync_match

// File: src/rsc_top.sv
// Receive sync/correlator configuration registers with AXI4-Lite slave
// Summary of operation
// - Software byte holds low eight bits of start-of-frame pattern.
// - Software byte holds high byte of start-of-frame pattern.
// - Four-bit length field limits how many pattern bits are matched.
// - Negative-edge bit sets grid at first correlation falling edge.
// - Half-last bit makes final sync bit half length.
// - Kind 0 burst of 16, 2 start-bit resync, 3 reserved.
// - Kind 1 reads each nibble as data bit plus collision flag.
// - Collision flag set means data ignored, collision expected.
// - Averaging bit combines four samples into one value.
// - Shaping bit squares converter samples before processing.
// - Grid polarity bit picks correlation maximum or minimum.
// - Polarity clear decodes subcarrier then no subcarrier.
// - FSK bit selects frequency-shift demodulation.
// - BPSK bit selects phase-shift modulation scheme.
// - Rate field sets clocks per correlation; value 3 reserved.
// - Window bit selects 32 values when set, else 64.
module rsc_top
   import rsc_pkg::*;
#(
   parameter int SW = 8
) (
   input  wire logic                        clk,
   input  wire logic                        rst_b,
   input  wire logic [rsc_pkg::ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic                        s_axi_awvalid,
   output      logic                        s_axi_awready,
   input  wire logic [31:0]                 s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output      logic                        s_axi_wready,
   output      logic [1:0]                  s_axi_bresp,
   output      logic                        s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   input  wire logic [rsc_pkg::ADDR_W-1:0]  s_axi_araddr,
   input  wire logic                        s_axi_arvalid,
   output      logic                        s_axi_arready,
   output      logic [31:0]                 s_axi_rdata,
   output      logic [1:0]                  s_axi_rresp,
   output      logic                        s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   input  wire logic                        smp_valid,
   input  wire logic [SW-1:0]               smp_data,
   input  wire logic                        corr_valid,
   input  wire logic                        corr_level,
   input  wire logic                        corr_peak,
   input  wire logic                        corr_trough,
   input  wire logic                        bit_valid,
   input  wire logic                        bit_data,
   input  wire logic                        bit_coll,
   input  wire logic                        frame_start,
   output      logic                        filt_valid,
   output      logic [SW-1:0]               filt_data,
   output      logic                        grid_strobe,
   output      logic                        half_length_final_bit,
   output      logic                        use_fsk,
   output      logic                        use_bpsk,
   output      logic                        manchester_polarity,
   output      logic [1:0]                  subcarrier_sel,
   output      logic [1:0]                  correlation_rate,
   output      logic                        rate_reserved,
   output      logic [6:0]                  correlation_len,
   output      logic [7:0]                  receiver_factory_trim,
   output      logic                        sof_found,
   output      logic                        sof_error
);
   import rsc_pkg::*;
   if (SW < 2 || SW > 16) begin : g_bad_sw
      $error("SW out of range");
   end
   typedef struct packed {
      logic        aw_got;
      logic [7:0]  aw_idx;
      logic        w_got;
      logic [31:0] wdat;
      logic [3:0]  wstb;
      logic        bvld;
      logic [1:0]  bresp;
      logic        rvld;
      logic [31:0] rdat;
      logic [1:0]  rresp;
      logic [7:0]  sof_high;
      logic [7:0]  sof_low;
      logic [7:0]  sync_mode;
      logic [7:0]  demod;
      logic [7:0]  corr;
      logic [7:0]  trim;
      logic        corr_prev;
      logic        edge_seen;
      logic        grid;
      logic        found_sticky;
      logic        err_sticky;
   } rsc_st_t;
   rsc_st_t st_ff, nxt_st;
   function automatic logic idx_known(input logic [7:0] idx);
      return idx >= IDX_SOF_HIGH && idx <= IDX_STATUS;
   endfunction : idx_known
   function automatic logic [7:0] idx_of(input logic [ADDR_W-1:0] a);
      return a[ADDR_W-1:2];
   endfunction : idx_of
   logic [15:0] sof_pattern_value;
   logic        aw_fire;
   logic        w_fire;
   logic        do_write;
   logic [7:0]  wbyte;
   logic [7:0]  rd_idx;
   logic        m_found;
   logic        m_err;
   logic [3:0]  m_idx;
   assign sof_pattern_value = {st_ff.sof_high, st_ff.sof_low};
   assign s_axi_awready = !st_ff.aw_got && !st_ff.bvld;
   assign s_axi_wready  = !st_ff.w_got && !st_ff.bvld;
   assign s_axi_arready = !st_ff.rvld;
   assign aw_fire  = s_axi_awvalid && s_axi_awready;
   assign w_fire   = s_axi_wvalid && s_axi_wready;
   assign do_write = (st_ff.aw_got || aw_fire) && (st_ff.w_got || w_fire);
   assign rd_idx   = idx_of(s_axi_araddr);
   always_comb begin
      logic [7:0]  widx;
      logic [31:0] wd;
      logic        wl;
      widx  = aw_fire ? idx_of(s_axi_awaddr) : st_ff.aw_idx;
      wd    = w_fire ? s_axi_wdata : st_ff.wdat;
      wl    = w_fire ? s_axi_wstrb[0] : st_ff.wstb[0];
      wbyte = wd[7:0];
      nxt_st = st_ff;
      if (aw_fire) begin
         nxt_st.aw_got = 1'b1;
         nxt_st.aw_idx = idx_of(s_axi_awaddr);
      end
      if (w_fire) begin
         nxt_st.w_got = 1'b1;
         nxt_st.wdat  = s_axi_wdata;
         nxt_st.wstb  = s_axi_wstrb;
      end
      if (st_ff.bvld && s_axi_bready) begin
         nxt_st.bvld = 1'b0;
      end
      if (do_write) begin
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got  = 1'b0;
         nxt_st.bvld   = 1'b1;
         nxt_st.bresp  = idx_known(widx) ? RESP_OKAY : RESP_SLVERR;
         if (wl) begin
            case (widx)
               IDX_SOF_HIGH:  nxt_st.sof_high  = wbyte;
               IDX_SOF_LOW:   nxt_st.sof_low   = wbyte;
               IDX_SYNC_MODE: nxt_st.sync_mode = wbyte;
               IDX_DEMOD:     nxt_st.demod     = wbyte & DEMOD_MASK;
               IDX_CORR:      nxt_st.corr      = wbyte & CORR_MASK;
               // trim stays writable; software keeps boot value
               IDX_TRIM:      nxt_st.trim      = wbyte;
               default:       nxt_st.trim      = st_ff.trim;
            endcase
         end
      end
      if (st_ff.rvld && s_axi_rready) begin
         nxt_st.rvld = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         nxt_st.rvld  = 1'b1;
         nxt_st.rresp = idx_known(rd_idx) ? RESP_OKAY : RESP_SLVERR;
         case (rd_idx)
            IDX_SOF_HIGH:  nxt_st.rdat = {24'h000000, st_ff.sof_high};
            IDX_SOF_LOW:   nxt_st.rdat = {24'h000000, st_ff.sof_low};
            IDX_SYNC_MODE: nxt_st.rdat = {24'h000000, st_ff.sync_mode};
            IDX_DEMOD:     nxt_st.rdat = {24'h000000, st_ff.demod};
            IDX_CORR:      nxt_st.rdat = {24'h000000, st_ff.corr};
            IDX_TRIM:      nxt_st.rdat = {24'h000000, st_ff.trim};
            IDX_STATUS:    nxt_st.rdat = {24'h000000, m_idx, 2'h0,
                                          st_ff.err_sticky, st_ff.found_sticky};
            default:       nxt_st.rdat = 32'h00000000;
         endcase
      end
      // Status stickies: a new event wins over a read clear
      if (s_axi_arvalid && s_axi_arready && rd_idx == IDX_STATUS) begin
         nxt_st.found_sticky = 1'b0;
         nxt_st.err_sticky   = 1'b0;
      end
      if (m_found) begin
         nxt_st.found_sticky = 1'b1;
      end
      if (m_err) begin
         nxt_st.err_sticky = 1'b1;
      end
      // Bit grid placement
      nxt_st.grid = 1'b0;
      if (frame_start) begin
         nxt_st.edge_seen = 1'b0;
         nxt_st.corr_prev = 1'b0;
      end else if (corr_valid) begin
         nxt_st.corr_prev = corr_level;
         if (st_ff.sync_mode[SM_NEG_EDGE]) begin
            if (!st_ff.edge_seen && st_ff.corr_prev && !corr_level) begin
               nxt_st.grid      = 1'b1;
               nxt_st.edge_seen = 1'b1;
            end
         end else begin
            nxt_st.grid = st_ff.demod[DM_PEAK] ? corr_peak : corr_trough;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st_ff           <= '0;
         st_ff.sof_high  <= RST_SOF_HIGH;
         st_ff.sof_low   <= RST_SOF_LOW;
         st_ff.sync_mode <= RST_SYNC_MODE;
         st_ff.demod     <= RST_DEMOD;
         st_ff.corr      <= RST_CORR;
         st_ff.trim      <= RST_TRIM;
      end else begin
         st_ff <= nxt_st;
      end
   end
   assign s_axi_bvalid = st_ff.bvld;
   assign s_axi_bresp  = st_ff.bresp;
   assign s_axi_rvalid = st_ff.rvld;
   assign s_axi_rdata  = st_ff.rdat;
   assign s_axi_rresp  = st_ff.rresp;
   assign grid_strobe  = st_ff.grid;
   assign half_length_final_bit = st_ff.sync_mode[SM_HALF];
   assign use_fsk  = st_ff.demod[DM_FSK];
   assign use_bpsk = st_ff.demod[DM_BPSK];
   assign manchester_polarity = st_ff.demod[DM_POL];
   assign subcarrier_sel = (st_ff.corr[CR_FREQ_LSB +: 2] == 2'h3) ? RSC_F848
                           : st_ff.corr[CR_FREQ_LSB +: 2];
   assign correlation_rate = st_ff.corr[CR_RATE_LSB +: 2];
   assign rate_reserved    = st_ff.corr[CR_RATE_LSB +: 2] == 2'h3;
   assign correlation_len = st_ff.corr[CR_WIN] ? WIN_SHORT : WIN_LONG;
   assign receiver_factory_trim = st_ff.trim;
   assign sof_found = m_found;
   assign sof_error = m_err;
   rsc_four_sample_average #(
      .SW (SW)
   ) u_pf (
      .clk                 (clk),
      .rst_b               (rst_b),
      .square_shaping      (st_ff.demod[DM_SQUARE]),
      .four_sample_average (st_ff.demod[DM_AVG]),
      .smp_valid           (smp_valid),
      .smp_data            (smp_data),
      .out_valid           (filt_valid),
      .out_data            (filt_data)
   );
   rsc_sync_match u_sm (
      .clk                  (clk),
      .rst_b                (rst_b),
      .sof_pattern_value    (sof_pattern_value),
      .sync_valid_bit_count (st_ff.sync_mode[SM_LEN_LSB +: 4]),
      .sync_pattern_kind    (st_ff.sync_mode[SM_KIND_LSB +: 2]),
      .bit_valid            (bit_valid),
      .bit_data             (bit_data),
      .bit_coll             (bit_coll),
      .frame_start          (frame_start),
      .sof_found            (m_found),
      .sof_error            (m_err),
      .bit_index            (m_idx)
   );
   AST_LOW_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
      do_write && (aw_fire ? idx_of(s_axi_awaddr) : st_ff.aw_idx) == IDX_SOF_LOW
      && (w_fire ? s_axi_wstrb[0] : st_ff.wstb[0])
      |=> sof_pattern_value[7:0] == $past(wbyte))
      else $error("low pattern byte not stored");
   AST_HIGH_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
      do_write && (aw_fire ? idx_of(s_axi_awaddr) : st_ff.aw_idx) == IDX_SOF_HIGH
      && (w_fire ? s_axi_wstrb[0] : st_ff.wstb[0])
      |=> sof_pattern_value[15:8] == $past(wbyte))
      else $error("high pattern byte not stored");
   AST_WIN: assert property (@(posedge clk) disable iff (!rst_b)
      correlation_len == (st_ff.corr[CR_WIN] ? 7'h20 : 7'h40))
      else $error("window length wrong");
   AST_FREQ: assert property (@(posedge clk) disable iff (!rst_b)
      st_ff.corr[7] |-> subcarrier_sel == 2'h2)
      else $error("848k not selected");
   AST_EDGE_ONCE: assert property (@(posedge clk) disable iff (!rst_b)
      grid_strobe && st_ff.sync_mode[SM_NEG_EDGE] && !frame_start
      |=> !grid_strobe)
      else $error("second falling-edge grid");
   AST_PEAK: assert property (@(posedge clk) disable iff (!rst_b)
      corr_valid && !frame_start && !st_ff.sync_mode[SM_NEG_EDGE]
      && st_ff.demod[DM_PEAK] |=> grid_strobe == $past(corr_peak))
      else $error("grid not at maximum");
   AST_FSK: assert property (@(posedge clk) disable iff (!rst_b)
      use_fsk == st_ff.demod[1] && use_bpsk == st_ff.demod[0])
      else $error("scheme select wrong");
   AST_RATE: assert property (@(posedge clk) disable iff (!rst_b)
      rate_reserved |-> correlation_rate == 2'h3)
      else $error("rate reserved flag wrong");
   AST_BRESP: assert property (@(posedge clk) disable iff (!rst_b)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   AST_TROUGH: assert property (@(posedge clk) disable iff (!rst_b)
      corr_valid && !frame_start && !st_ff.sync_mode[SM_NEG_EDGE]
      && !st_ff.demod[DM_PEAK] |=> grid_strobe == $past(corr_trough))
      else $error("grid not at minimum");
   AST_RSVD_BITS: assert property (@(posedge clk) disable iff (!rst_b)
      st_ff.demod[7:6] == 2'h0 && st_ff.corr[2:0] == 3'h0)
      else $error("reserved bits set");
   AST_RHOLD: assert property (@(posedge clk) disable iff (!rst_b)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   AST_BUSY: assert property (@(posedge clk) disable iff (!rst_b)
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during response");
   AST_STICKY: assert property (@(posedge clk) disable iff (!rst_b)
      m_found |=> st_ff.found_sticky)
      else $error("found event lost");
   AST_TRIM_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
      !do_write |=> $stable(receiver_factory_trim))
      else $error("trim changed without write");
   COV_WRITE: cover property (@(posedge clk) disable iff (!rst_b) do_write);
   COV_READ: cover property (@(posedge clk) disable iff (!rst_b)
      s_axi_rvalid && s_axi_rready);
   COV_SOF: cover property (@(posedge clk) disable iff (!rst_b) sof_found);
endmodule : rsc_top

// File: dv/rsc_card_model.sv
// Card side model: sends start-of-frame bits most significant first
module rsc_card_model (
   input  wire logic        clk,
   input  wire logic        go,
   input  wire logic [15:0] pat,
   input  wire logic [15:0] cmask,
   output      logic        bit_valid,
   output      logic        bit_data,
   output      logic        bit_coll
);
   timeunit 1ns;
   timeprecision 1ns;
   int n = -1;
   always @(posedge clk) begin
      bit_valid <= n >= 0;
      bit_coll  <= n >= 0 && cmask[n];
      if (n >= 0) begin
         bit_data <= pat[n];
         n        <= n - 1;
      end else begin
         // Idle line toggles every cycle, starting with the inverse of the last bit
         bit_data <= (bit_data !== 1'b1);
         if (go) n <= 15;
      end
   end
endmodule : rsc_card_model

// File: dv/tb.sv
// Testbench for the receive sync and correlator configuration block
module tb;
   import rsc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst_b = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, go = 0, fs = 0;
   logic [9:0] aa = 0, ra = 0;
   logic [31:0] wd = 0, rd_d;
   logic awr, wr_r, bv, arr, rv, bvl, bc, bd, hf, fsk, bpsk, pol, rres, sf;
   logic [1:0] bresp, rresp, sc, rate;
   logic [6:0] wlen;
   logic [7:0] trim;
   logic fv, gs, se;
   logic [7:0] fd;
   logic [15:0] pat = 16'hA53C, cm = 0;
   int cyc = 0, num_errors = 0, check_count = 0;
   rsc_top i_dut (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(aa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
      .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
      .s_axi_araddr(ra), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd_d),
      .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .smp_valid(cyc[0]),
      .smp_data(cyc[8:1]), .corr_valid(cyc[1]), .corr_level(cyc[3]), .corr_peak(cyc[4]),
      .corr_trough(cyc[5]), .bit_valid(bvl), .bit_data(bd), .bit_coll(bc), .frame_start(fs),
      .filt_valid(fv), .filt_data(fd), .grid_strobe(gs), .half_length_final_bit(hf),
      .use_fsk(fsk), .use_bpsk(bpsk), .manchester_polarity(pol), .subcarrier_sel(sc),
      .correlation_rate(rate), .rate_reserved(rres), .correlation_len(wlen),
      .receiver_factory_trim(trim), .sof_found(sf), .sof_error(se));
   rsc_card_model i_card (.clk(clk), .go(go), .pat(pat), .cmask(cm), .bit_valid(bvl),
      .bit_data(bd), .bit_coll(bc));
   initial forever #5 clk = ~clk;
   task automatic print_verdict;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         print_verdict();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
      @(posedge clk);
      aa <= {idx, 2'h0}; wd <= {24'h0, d}; awv <= 1; wv <= 1; br <= 1;
      do begin
         @(posedge clk);
         if (awr) awv <= 0;
         if (wr_r) wv <= 0;
      end while (bv !== 1'b1);
      br <= 0;
      chk(bresp, er);
   endtask : wr
   task automatic rd(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
      @(posedge clk);
      ra <= {idx, 2'h0}; arv <= 1; rr <= 1;
      do begin
         @(posedge clk);
         if (arr) arv <= 0;
      end while (rv !== 1'b1);
      rr <= 0;
      chk(rresp, er);
      chk(rd_d, {24'h0, d});
   endtask : rd
   task automatic t_reset;
      rd(IDX_SOF_HIGH, RST_SOF_HIGH, RESP_OKAY);
      rd(IDX_SOF_LOW, RST_SOF_LOW, RESP_OKAY);
      rd(IDX_SYNC_MODE, RST_SYNC_MODE, RESP_OKAY);
      rd(IDX_DEMOD, RST_DEMOD, RESP_OKAY);
      rd(IDX_CORR, RST_CORR, RESP_OKAY);
      rd(IDX_TRIM, RST_TRIM, RESP_OKAY);
      chk(wlen, WIN_LONG);
      chk(trim, RST_TRIM);
   endtask : t_reset
   task automatic t_fields;
      wr(IDX_DEMOD, 8'hFF, RESP_OKAY);
      rd(IDX_DEMOD, DEMOD_MASK, RESP_OKAY);
      chk({fsk, bpsk, pol}, 3'h7);
      wr(IDX_CORR, 8'hCF, RESP_OKAY);
      rd(IDX_CORR, 8'hC8, RESP_OKAY);
      chk({sc, rate, wlen}, {2'h2, 2'h0, WIN_SHORT});
      wr(IDX_CORR, 8'h70, RESP_OKAY);
      chk({sc, rate, rres, wlen}, {2'h1, 2'h3, 1'b1, WIN_LONG});
      wr(IDX_SYNC_MODE, 8'h04, RESP_OKAY);
      chk(hf, 1'b1);
      wr(8'h10, 8'h55, RESP_SLVERR);
      rd(8'h10, 8'h00, RESP_SLVERR);
   endtask : t_fields
   task automatic sof_run(input logic [7:0] mode, input logic [15:0] p, input logic [15:0] m,
                          input logic exp_ok);
      int nf, ne;
      nf = 0;
      ne = 0;
      wr(IDX_SYNC_MODE, mode, RESP_OKAY);
      pat <= p;
      cm  <= m;
      fs  <= 1;
      @(posedge clk);
      fs <= 0;
      go <= 1;
      @(posedge clk);
      go <= 0;
      repeat (40) begin
         @(posedge clk);
         nf += (sf === 1'b1);
         ne += (se === 1'b1);
      end
      chk(nf, exp_ok);
      chk(ne, !exp_ok);
   endtask : sof_run
   task automatic t_sof;
      wr(IDX_SOF_HIGH, 8'hA5, RESP_OKAY);
      wr(IDX_SOF_LOW, 8'h3C, RESP_OKAY);
      sof_run(8'h80, 16'hA53C, 16'h0, 1);
      sof_run(8'h80, 16'hA43C, 16'h0, 0);
      sof_run(8'h70, 16'hA43C, 16'h0, 1);
      wr(IDX_SOF_HIGH, 8'h10, RESP_OKAY);
      wr(IDX_SOF_LOW, 8'h21, RESP_OKAY);
      sof_run(8'h41, 16'h4000, 16'h9000, 1);
      sof_run(8'h41, 16'h0000, 16'h9000, 0);
      sof_run(8'h02, 16'h0000, 16'h0, 1);
      sof_run(8'h02, 16'h8000, 16'h0, 0);
      sof_run(8'h03, 16'h0000, 16'h0, 0);
   endtask : t_sof
   task automatic t_grid;
      int n, p;
      n = 0;
      wr(IDX_SYNC_MODE, 8'h08, RESP_OKAY);
      fs <= 1;
      @(posedge clk);
      fs <= 0;
      repeat (40) begin
         @(posedge clk);
         n += (gs === 1'b1);
      end
      chk(n, 1);
      wr(IDX_SYNC_MODE, 8'h00, RESP_OKAY);
      repeat (20) begin
         @(posedge clk);
         p = cyc - 1;
         chk(gs, p[1] & p[4]);
      end
      wr(IDX_DEMOD, 8'h10, RESP_OKAY);
      repeat (20) begin
         @(posedge clk);
         p = cyc - 1;
         chk(fv, p[0]);
         if (fv === 1'b1) chk(fd, {8{p[8]}});
      end
      n = 0;
      wr(IDX_DEMOD, 8'h20, RESP_OKAY);
      repeat (40) begin
         @(posedge clk);
         n += (fv === 1'b1);
      end
      chk(n, 5);
   endtask : t_grid
   initial begin
      repeat (2) @(posedge clk);
      rst_b <= 1;
      t_reset();
      t_fields();
      t_grid();
      t_sof();
      print_verdict();
   end
endmodule : tb
